// *** hw/afe_cfg.svh ***
/*
 Register map constants for the analog front-end control registers:
 indices, reset values, writable masks, field positions and gain values.
 Assumes nothing; definitions only.
*/
`ifndef AFE_CFG_SVH
`define AFE_CFG_SVH
// Register indices; byte address is index shifted left by two
`define AFE_IDX_DROP_HI 8'h0F
`define AFE_IDX_DROP_LO 8'h10
`define AFE_IDX_THR_HI 8'h11
`define AFE_IDX_THR_LO 8'h12
`define AFE_IDX_GAIN 8'h13
`define AFE_IDX_PWR 8'h14
`define AFE_IDX_SHIFT 2
// Slot of each register in the decode vector
`define AFE_NUM_REGS 6
`define AFE_SLOT_DROP_HI 0
`define AFE_SLOT_DROP_LO 1
`define AFE_SLOT_THR_HI 2
`define AFE_SLOT_THR_LO 3
`define AFE_SLOT_GAIN 4
`define AFE_SLOT_PWR 5
// Reset values
`define AFE_RST_BYTE 8'h00
`define AFE_RST_GAIN 8'h50
`define AFE_RST_PWR 8'hCF
// Writable masks; reserved bits read zero
`define AFE_MASK_FULL 8'hFF
`define AFE_MASK_GAIN 8'hF0
`define AFE_MASK_PWR 8'hCF
// Field positions
`define AFE_GAIN_CUR_HI 7
`define AFE_GAIN_CUR_LO 6
`define AFE_GAIN_VOL_HI 5
`define AFE_GAIN_VOL_LO 4
`define AFE_PWR_CHOP_CUR 7
`define AFE_PWR_CHOP_VOL 6
`define AFE_PWR_AMP_CUR 3
`define AFE_PWR_MOD_CUR 2
`define AFE_PWR_AMP_VOL 1
`define AFE_PWR_MOD_VOL 0
// Amplifier gain values
`define AFE_GAIN_W 7
`define AFE_GAIN_X5 7'h05
`define AFE_GAIN_X25 7'h19
`define AFE_GAIN_X40 7'h28
`define AFE_GAIN_X100 7'h64
`endif

// *** hw/afe_pkg.sv ***
/*
 Types shared by the front-end control register files.
 Assumes afe_cfg.svh on the include path.
*/
`include "afe_cfg.svh"
package afe_pkg;
   // Amplifier gain codes
   typedef enum logic [1:0] {
      AFE_G5 = 2'h0,
      AFE_G25 = 2'h1,
      AFE_G40 = 2'h2,
      AFE_G100 = 2'h3
   } afe_gain_e;
   typedef logic [`AFE_NUM_REGS-1:0] afe_hit_t;
   typedef logic [`AFE_GAIN_W-1:0] afe_gval_t;
   // Register file state
   typedef struct packed {
      logic [7:0] drop_hi;
      logic [7:0] drop_lo;
      logic [7:0] thr_hi;
      logic [7:0] thr_lo;
      logic [7:0] gain;
      logic [7:0] pwr;
      logic [31:0] rdata;
      logic pwr_wr;
   } afe_regs_s;
   // Gain decoder state
   typedef struct packed {
      afe_gval_t gain;
   } afe_gdec_s;
endpackage

// *** hw/afe_acc_if.sv ***
/*
 Access interface between the register core and its address decoder.
 Assumes afe_pkg compiled first.
*/
`timescale 1ns/1ps
interface afe_acc_if #(parameter int ADDR_W = 8);
   import afe_pkg::*;
   logic [ADDR_W-1:0] paddr;
   logic psel;
   logic penable;
   logic pwrite;
   logic [3:0] pstrb;
   afe_hit_t hit;
   logic mapped;
   logic wr_en;
   logic rd_setup;
   modport dec (input paddr, psel, penable, pwrite, pstrb,
      output hit, mapped, wr_en, rd_setup);
   modport core (output paddr, psel, penable, pwrite, pstrb,
      input hit, mapped, wr_en, rd_setup);
endinterface

// *** hw/afe_apb_dec.sv ***
/*
 APB address decoder: one-hot register hit, write strobe, read setup.
 Assumes a zero-wait slave that always answers in the access phase.
*/
`timescale 1ns/1ps
`include "afe_cfg.svh"
module afe_apb_dec
   import afe_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   afe_acc_if.dec acc
);
   localparam logic [7:0] IDX [`AFE_NUM_REGS] = '{`AFE_IDX_DROP_HI, `AFE_IDX_DROP_LO,
      `AFE_IDX_THR_HI, `AFE_IDX_THR_LO, `AFE_IDX_GAIN, `AFE_IDX_PWR};

   // Highest byte address must fit the address bus
   if (ADDR_W < 7) begin : g_chk
      $error("afe_apb_dec: ADDR_W too small");
   end

   // Per-register address compare
   for (genvar i = 0; i < `AFE_NUM_REGS; i++) begin : g_hit
      assign acc.hit[i] = acc.paddr == (ADDR_W'(IDX[i]) << `AFE_IDX_SHIFT);
   end

   // Strobes; a write needs the low byte lane
   assign acc.mapped = |acc.hit;
   assign acc.wr_en = acc.psel & acc.penable & acc.pwrite & acc.mapped & acc.pstrb[0];
   assign acc.rd_setup = acc.psel & ~acc.penable & ~acc.pwrite;
endmodule

// *** hw/afe_gain_dec.sv ***
/*
 Registered decode of a two-bit amplifier gain code to its gain value.
 Assumes code comes from a register on the same clock.
*/
`timescale 1ns/1ps
`include "afe_cfg.svh"
module afe_gain_dec
   import afe_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [1:0] code,
   output afe_gval_t gain
);
   afe_gdec_s s_r;
   afe_gdec_s s_nxt;

   // Code to gain lookup
   always_comb begin
      s_nxt = s_r;
      case (afe_gain_e'(code))
         AFE_G5: s_nxt.gain = `AFE_GAIN_X5;
         AFE_G25: s_nxt.gain = `AFE_GAIN_X25;
         AFE_G40: s_nxt.gain = `AFE_GAIN_X40;
         AFE_G100: s_nxt.gain = `AFE_GAIN_X100;
         default: s_nxt.gain = `AFE_GAIN_X25;
      endcase
   end

   // State register; reset value matches the default code
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r.gain <= `AFE_GAIN_X25;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign gain = s_r.gain;
endmodule

// *** hw/afe_ctrl_regs.sv ***
/*
 Analog front-end control register bank on an APB slave: sample drop
 interval and current threshold for threshold-triggered normal mode,
 amplifier gains and analog power enables of both channels.
 Assumes a single clock pclk, an APB master on the same clock, and the
 acquisition datapath reading the outputs below.
*/
// Summary of operation
// - Hold 16-bit sample drop count, high byte then low byte at next address.
// - Hold 16-bit normal-mode current threshold, high byte then low byte.
// - Bits 5:4 pick voltage gain with the same codes, reset code 01.
// - Power bit 7 passes the current channel chopper clock when set.
// - Power bit 6 passes the voltage channel chopper clock when set.
// - Power bit 3 enables the current channel amplifier.
// - Power bit 2 enables the current channel modulator.
// - Power bit 1 enables the voltage channel amplifier.
// - Power bit 0 enables the voltage channel modulator.
// - Reset loads power register with all enables set, reserved bits clear.
`timescale 1ns/1ps
`include "afe_cfg.svh"
module afe_ctrl_regs
   import afe_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [15:0] sample_drop_interval,
   output logic [15:0] normal_current_threshold,
   output logic [1:0] gain_code_cur,
   output logic [1:0] gain_code_vol,
   output afe_gval_t gain_value_cur,
   output afe_gval_t gain_value_vol,
   output logic chop_clk_en_cur,
   output logic chop_clk_en_vol,
   output logic amp_en_cur,
   output logic mod_en_cur,
   output logic amp_en_vol,
   output logic mod_en_vol
);

   //****************************************************************
   // Declarations
   //****************************************************************
   afe_regs_s s_r;
   afe_regs_s s_nxt;
   logic [7:0] reg_arr [`AFE_NUM_REGS];
   logic [7:0] rd_byte;
   logic [1:0] ch_code [2];
   afe_gval_t ch_gain [2];

   afe_acc_if #(.ADDR_W(ADDR_W)) acc ();

   // Elaboration check on the address width
   if (ADDR_W < 7 || ADDR_W > 32) begin : g_chk
      $error("afe_ctrl_regs: ADDR_W out of range");
   end

   //****************************************************************
   // Bus decode
   //****************************************************************
   // Request side of the access interface
   assign acc.paddr = paddr;
   assign acc.psel = psel;
   assign acc.penable = penable;
   assign acc.pwrite = pwrite;
   assign acc.pstrb = pstrb;

   afe_apb_dec #(.ADDR_W(ADDR_W)) u_dec (
      .acc(acc)
   );

   // Zero-wait slave; unmapped access answers with an error
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~acc.mapped;

   //****************************************************************
   // Read mux
   //****************************************************************
   // Register image in decode-slot order
   assign reg_arr[`AFE_SLOT_DROP_HI] = s_r.drop_hi;
   assign reg_arr[`AFE_SLOT_DROP_LO] = s_r.drop_lo;
   assign reg_arr[`AFE_SLOT_THR_HI] = s_r.thr_hi;
   assign reg_arr[`AFE_SLOT_THR_LO] = s_r.thr_lo;
   assign reg_arr[`AFE_SLOT_GAIN] = s_r.gain;
   assign reg_arr[`AFE_SLOT_PWR] = s_r.pwr;

   // One-hot select; unmapped reads give zero
   always_comb begin
      rd_byte = `AFE_RST_BYTE;
      for (int i = 0; i < `AFE_NUM_REGS; i++) begin
         if (acc.hit[i]) begin
            rd_byte = rd_byte | reg_arr[i];
         end
      end
   end

   //****************************************************************
   // Next state
   //****************************************************************
   // Writes land at the access edge, read data is taken in setup
   always_comb begin
      s_nxt = s_r;
      if (acc.wr_en) begin
         if (acc.hit[`AFE_SLOT_DROP_HI]) begin
            s_nxt.drop_hi = pwdata[7:0] & `AFE_MASK_FULL;
         end
         if (acc.hit[`AFE_SLOT_DROP_LO]) begin
            s_nxt.drop_lo = pwdata[7:0] & `AFE_MASK_FULL;
         end
         if (acc.hit[`AFE_SLOT_THR_HI]) begin
            s_nxt.thr_hi = pwdata[7:0] & `AFE_MASK_FULL;
         end
         if (acc.hit[`AFE_SLOT_THR_LO]) begin
            s_nxt.thr_lo = pwdata[7:0] & `AFE_MASK_FULL;
         end
         if (acc.hit[`AFE_SLOT_GAIN]) begin
            s_nxt.gain = pwdata[7:0] & `AFE_MASK_GAIN;
         end
         if (acc.hit[`AFE_SLOT_PWR]) begin
            s_nxt.pwr = pwdata[7:0] & `AFE_MASK_PWR;
            s_nxt.pwr_wr = 1'b1;
         end
      end
      if (acc.rd_setup) begin
         s_nxt.rdata = 32'(rd_byte);
      end
   end

   //****************************************************************
   // State register
   //****************************************************************
   // Power-on values; reserved bits start clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r.drop_hi <= `AFE_RST_BYTE;
         s_r.drop_lo <= `AFE_RST_BYTE;
         s_r.thr_hi <= `AFE_RST_BYTE;
         s_r.thr_lo <= `AFE_RST_BYTE;
         s_r.gain <= `AFE_RST_GAIN;
         s_r.pwr <= `AFE_RST_PWR;
         s_r.rdata <= 32'h00000000;
         s_r.pwr_wr <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end

   //****************************************************************
   // Outputs
   //****************************************************************
   assign prdata = s_r.rdata;

   // Sixteen-bit settings, high byte first in the map
   assign sample_drop_interval = {s_r.drop_hi, s_r.drop_lo};
   assign normal_current_threshold = {s_r.thr_hi, s_r.thr_lo};

   // Gain codes
   assign gain_code_cur = s_r.gain[`AFE_GAIN_CUR_HI:`AFE_GAIN_CUR_LO];
   assign gain_code_vol = s_r.gain[`AFE_GAIN_VOL_HI:`AFE_GAIN_VOL_LO];
   assign ch_code[0] = gain_code_cur;
   assign ch_code[1] = gain_code_vol;

   // One gain decoder per channel
   for (genvar c = 0; c < 2; c++) begin : g_ch
      afe_gain_dec u_gain (
         .pclk(pclk),
         .presetn(presetn),
         .code(ch_code[c]),
         .gain(ch_gain[c])
      );
   end
   assign gain_value_cur = ch_gain[0];
   assign gain_value_vol = ch_gain[1];

   // Analog power and chopper clock enables
   assign chop_clk_en_cur = s_r.pwr[`AFE_PWR_CHOP_CUR];
   assign chop_clk_en_vol = s_r.pwr[`AFE_PWR_CHOP_VOL];
   assign amp_en_cur = s_r.pwr[`AFE_PWR_AMP_CUR];
   assign mod_en_cur = s_r.pwr[`AFE_PWR_MOD_CUR];
   assign amp_en_vol = s_r.pwr[`AFE_PWR_AMP_VOL];
   assign mod_en_vol = s_r.pwr[`AFE_PWR_MOD_VOL];

   //****************************************************************
   // Assertions
   //****************************************************************
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Drop interval high byte follows a write
   AST_DROP_HI: assert property (
      psel && penable && pwrite && pstrb[0] && paddr == (ADDR_W'(`AFE_IDX_DROP_HI) << 2)
      |=> sample_drop_interval[15:8] == $past(pwdata[7:0])
   ) else $error("drop interval high byte not written");

   // Drop interval low byte follows a write, high byte untouched
   AST_DROP_LO: assert property (
      psel && penable && pwrite && pstrb[0] && paddr == (ADDR_W'(`AFE_IDX_DROP_LO) << 2)
      |=> sample_drop_interval[7:0] == $past(pwdata[7:0]) && $stable(sample_drop_interval[15:8])
   ) else $error("drop interval low byte not written");

   // Threshold high byte
   AST_THR_HI: assert property (
      psel && penable && pwrite && pstrb[0] && paddr == (ADDR_W'(`AFE_IDX_THR_HI) << 2)
      |=> normal_current_threshold[15:8] == $past(pwdata[7:0])
   ) else $error("threshold high byte not written");

   // Threshold low byte
   AST_THR_LO: assert property (
      psel && penable && pwrite && pstrb[0] && paddr == (ADDR_W'(`AFE_IDX_THR_LO) << 2)
      |=> normal_current_threshold[7:0] == $past(pwdata[7:0])
   ) else $error("threshold low byte not written");

   // Current gain value follows its code one cycle later
   AST_GAIN_CUR: assert property (
      gain_code_cur == 2'h3 |=> gain_value_cur == `AFE_GAIN_X100
   ) else $error("current gain decode wrong");

   // Voltage gain code written lands, value follows a cycle after
   AST_GAIN_VOL: assert property (
      psel && penable && pwrite && pstrb[0] && paddr == (ADDR_W'(`AFE_IDX_GAIN) << 2)
      && pwdata[5:4] == 2'h2 |=> gain_code_vol == 2'h2 ##1 gain_value_vol == `AFE_GAIN_X40
   ) else $error("voltage gain code or value wrong");

   // Chopper enables match the written bits
   AST_CHOP: assert property (
      psel && penable && pwrite && pstrb[0] && paddr == (ADDR_W'(`AFE_IDX_PWR) << 2)
      |=> {chop_clk_en_cur, chop_clk_en_vol} == $past(pwdata[7:6])
   ) else $error("chopper enables not written");

   // Current channel amplifier and modulator enables
   AST_CUR_EN: assert property (
      psel && penable && pwrite && pstrb[0] && paddr == (ADDR_W'(`AFE_IDX_PWR) << 2)
      |=> {amp_en_cur, mod_en_cur} == $past(pwdata[3:2])
   ) else $error("current channel enables not written");

   // Voltage channel amplifier and modulator enables
   AST_VOL_EN: assert property (
      psel && penable && pwrite && pstrb[0] && paddr == (ADDR_W'(`AFE_IDX_PWR) << 2)
      |=> {amp_en_vol, mod_en_vol} == $past(pwdata[1:0])
   ) else $error("voltage channel enables not written");

   // Until the first power write every enable stands set
   AST_PWR_RST: assert property (
      !s_r.pwr_wr |-> chop_clk_en_cur && chop_clk_en_vol && amp_en_cur && mod_en_cur
      && amp_en_vol && mod_en_vol && s_r.pwr == `AFE_RST_PWR
   ) else $error("power register not at reset value");

   // Gain register reserved bits read back as zero
   AST_RSVD: assert property (
      psel && !penable && !pwrite && paddr == (ADDR_W'(`AFE_IDX_GAIN) << 2)
      |=> prdata[3:0] == 4'h0 && prdata[31:8] == 24'h000000
   ) else $error("reserved gain bits not zero");

   // Without a write the drop interval and threshold hold
   AST_HOLD: assert property (
      !(psel && penable && pwrite)
      |=> $stable(sample_drop_interval) && $stable(normal_current_threshold)
   ) else $error("setting changed without a write");

   // Unmapped access answers with an error and writes nothing
   AST_SLVERR: assert property (
      psel && penable && !acc.mapped |-> pslverr ##1 $stable(s_r.pwr) && $stable(s_r.gain)
   ) else $error("unmapped access not flagged");

   // Mapped access never answers with an error
   AST_SLVERR_OK: assert property (
      psel && penable && acc.mapped |-> !pslverr
   ) else $error("mapped access flagged as error");

   // Write without the low byte lane changes nothing
   AST_NO_STRB: assert property (
      psel && penable && pwrite && !pstrb[0]
      |=> $stable(sample_drop_interval) && $stable(normal_current_threshold)
      && $stable(s_r.gain) && $stable(s_r.pwr)
   ) else $error("write without byte strobe took effect");

   // Unmapped read returns zero
   AST_RD_UNMAPPED: assert property (
      psel && !penable && !pwrite && !acc.mapped |=> prdata == 32'h00000000
   ) else $error("unmapped read data not zero");

   // Drop interval high byte reads back
   AST_RD_DROP_HI: assert property (
      psel && !penable && !pwrite
      && paddr == (ADDR_W'(`AFE_IDX_DROP_HI) << `AFE_IDX_SHIFT)
      |=> prdata == 32'($past(sample_drop_interval[15:8]))
   ) else $error("drop interval high byte read wrong");

   // Threshold low byte reads back
   AST_RD_THR_LO: assert property (
      psel && !penable && !pwrite
      && paddr == (ADDR_W'(`AFE_IDX_THR_LO) << `AFE_IDX_SHIFT)
      |=> prdata == 32'($past(normal_current_threshold[7:0]))
   ) else $error("threshold low byte read wrong");

   // Power reserved bits read back as zero
   AST_RSVD_PWR: assert property (
      psel && !penable && !pwrite
      && paddr == (ADDR_W'(`AFE_IDX_PWR) << `AFE_IDX_SHIFT)
      |=> (prdata & ~32'(`AFE_MASK_PWR)) == 32'h00000000
   ) else $error("reserved power bits not zero");

   // Writes never set reserved bits
   AST_WR_RSVD: assert property (
      psel && penable && pwrite && pstrb[0]
      |=> (s_r.gain & ~`AFE_MASK_GAIN) == `AFE_RST_BYTE
      && (s_r.pwr & ~`AFE_MASK_PWR) == `AFE_RST_BYTE
   ) else $error("reserved bit set by a write");

   // Current gain decode, remaining codes
   AST_GAIN_CUR_X5: assert property (
      gain_code_cur == AFE_G5 |=> gain_value_cur == `AFE_GAIN_X5
   ) else $error("current gain 5 decode wrong");
   AST_GAIN_CUR_X25: assert property (
      gain_code_cur == AFE_G25 |=> gain_value_cur == `AFE_GAIN_X25
   ) else $error("current gain 25 decode wrong");
   AST_GAIN_CUR_X40: assert property (
      gain_code_cur == AFE_G40 |=> gain_value_cur == `AFE_GAIN_X40
   ) else $error("current gain 40 decode wrong");

   // Voltage gain decode, every code
   AST_GAIN_VOL_X5: assert property (
      gain_code_vol == AFE_G5 |=> gain_value_vol == `AFE_GAIN_X5
   ) else $error("voltage gain 5 decode wrong");
   AST_GAIN_VOL_X25: assert property (
      gain_code_vol == AFE_G25 |=> gain_value_vol == `AFE_GAIN_X25
   ) else $error("voltage gain 25 decode wrong");
   AST_GAIN_VOL_X40: assert property (
      gain_code_vol == AFE_G40 |=> gain_value_vol == `AFE_GAIN_X40
   ) else $error("voltage gain 40 decode wrong");
   AST_GAIN_VOL_X100: assert property (
      gain_code_vol == AFE_G100 |=> gain_value_vol == `AFE_GAIN_X100
   ) else $error("voltage gain 100 decode wrong");

endmodule

// *** verification/afe_ctrl_regs_tb.sv ***
/*
 Self-checking bench for the front-end control register bank over APB.
 Assumes afe_pkg and afe_cfg.svh compiled first, design ADDR_W of 8.
*/
`timescale 1ns/1ps
`include "afe_cfg.svh"
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin errors++; \
   $display("[FAIL] %0t mismatch got %h exp %h", $time, got, exp); end end
module afe_ctrl_regs_tb
   import afe_pkg::*;
;
   // ****************************************
   // Signals and expected state
   // ****************************************
   typedef struct packed {
      logic [31:0] d;
      logic e;
      logic rd;
   } afe_note_s;
   localparam logic [7:0] IDX [6] = '{`AFE_IDX_DROP_HI, `AFE_IDX_DROP_LO, `AFE_IDX_THR_HI,
      `AFE_IDX_THR_LO, `AFE_IDX_GAIN, `AFE_IDX_PWR};
   localparam logic [7:0] RST [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h50, 8'hCF};
   localparam logic [7:0] MSK [6] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hF0, 8'hCF};
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb;
   logic [15:0] sample_drop_interval, normal_current_threshold;
   logic [1:0] gain_code_cur, gain_code_vol;
   afe_gval_t gain_value_cur, gain_value_vol;
   logic chop_clk_en_cur, chop_clk_en_vol, amp_en_cur, mod_en_cur, amp_en_vol, mod_en_vol;
   logic [7:0] exp_r [6];
   afe_note_s q [$];
   afe_note_s note;
   int errors = 0;
   int n_checks = 0;
   int cyc = 0;
   integer seed = 42;
   logic [31:0] rv;

   afe_ctrl_regs #(.ADDR_W(8)) u_afe_ctrl_regs (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sample_drop_interval(sample_drop_interval),
      .normal_current_threshold(normal_current_threshold), .gain_code_cur(gain_code_cur),
      .gain_code_vol(gain_code_vol), .gain_value_cur(gain_value_cur),
      .gain_value_vol(gain_value_vol), .chop_clk_en_cur(chop_clk_en_cur),
      .chop_clk_en_vol(chop_clk_en_vol), .amp_en_cur(amp_en_cur), .mod_en_cur(mod_en_cur),
      .amp_en_vol(amp_en_vol), .mod_en_vol(mod_en_vol));

   // Clock, 20 ns period
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   // ****************************************
   // Tasks
   // ****************************************
   task automatic test_done();
      if (errors == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // One APB transfer; psel stays up so the next setup may follow at once
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s, input logic [31:0] xd, input logic xe);
      q.push_back('{d: xd, e: xe, rd: ~wr});
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      // Wait for the answer; only the bench timeout ends a hang
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
   endtask

   task automatic idle();
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // Write a slot with random upper data bits, track expected byte
   task automatic wr(input int sl, input logic [7:0] v);
      rv = $random(seed);
      apb(1'b1, IDX[sl] << `AFE_IDX_SHIFT, {rv[31:8], v}, 4'hF, 32'h0, 1'b0);
      exp_r[sl] = v & MSK[sl];
   endtask

   task automatic read_all();
      for (int i = 0; i < 6; i++) apb(1'b0, IDX[i] << `AFE_IDX_SHIFT, 32'h0, 4'h0,
         {24'h0, exp_r[i]}, 1'b0);
      idle();
   endtask

   function automatic afe_gval_t gv(input logic [1:0] c);
      case (c)
         2'h0: return 7'h05;
         2'h1: return 7'h19;
         2'h2: return 7'h28;
         default: return 7'h64;
      endcase
   endfunction

   // Compare every setting output with the expected bytes
   task automatic check_outs();
      repeat (2) @(posedge pclk);
      `CHK(sample_drop_interval, {exp_r[0], exp_r[1]})
      `CHK(normal_current_threshold, {exp_r[2], exp_r[3]})
      `CHK(gain_code_cur, exp_r[4][7:6])
      `CHK(gain_value_cur, gv(exp_r[4][7:6]))
      `CHK(gain_code_vol, exp_r[4][5:4])
      `CHK(gain_value_vol, gv(exp_r[4][5:4]))
      `CHK(chop_clk_en_cur, exp_r[5][7])
      `CHK(chop_clk_en_vol, exp_r[5][6])
      `CHK(amp_en_cur, exp_r[5][3])
      `CHK(mod_en_cur, exp_r[5][2])
      `CHK(amp_en_vol, exp_r[5][1])
      `CHK(mod_en_vol, exp_r[5][0])
   endtask

   // ****************************************
   // Monitor and timeout
   // ****************************************
   // Each completed access takes the oldest note
   always @(posedge pclk) begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
         note = q.pop_front();
         if (note.rd) `CHK(prdata, note.d)
         `CHK(pslverr, note.e)
      end
   end

   always @(posedge pclk) begin
      cyc++;
      if (cyc == 8000) begin
         errors++;
         test_done();
      end
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pstrb = 4'h0;
      exp_r = RST;
      // Reset spans six edges, the last two inside the check
      repeat (4) @(posedge pclk);
      check_outs();
      presetn <= 1'b1;
      @(posedge pclk);
      check_outs();
      read_all();
      // Random 16-bit settings, bytes written back to back
      for (int i = 0; i < 12; i++) begin
         rv = $random(seed);
         wr(i % 4, rv[7:0]);
         if (i % 3 == 2) begin
            idle();
            check_outs();
         end
      end
      read_all();
      // Every gain code pair, reserved bits written as ones
      for (int c = 0; c < 16; c++) begin
         wr(4, {c[3:0], 4'hF});
         idle();
         check_outs();
      end
      read_all();
      // Walking one and random power values
      for (int i = 0; i < 12; i++) begin
         rv = $random(seed);
         wr(5, (i < 8) ? (8'h01 << i) : rv[7:0]);
         idle();
         check_outs();
      end
      read_all();
      // Unmapped accesses and a write with byte strobe off
      apb(1'b1, 8'h54, 32'hFF, 4'hF, 32'h0, 1'b1);
      apb(1'b0, 8'h38, 32'h0, 4'h0, 32'h0, 1'b1);
      apb(1'b1, IDX[5] << `AFE_IDX_SHIFT, 32'h30, 4'hE, 32'h0, 1'b0);
      idle();
      check_outs();
      read_all();
      // Reset in mid-run
      presetn <= 1'b0;
      exp_r = RST;
      check_outs();
      presetn <= 1'b1;
      @(posedge pclk);
      read_all();
      test_done();
   end
endmodule
